/* src/aps_sequencer.sv */
// automatic program stage sequencer with apb register access
//
// How it works
// - mode zero disables sequencer; normal reference passes
// - modes 1,4 run one cycle then stop
// - modes 2,5 repeat the cycle forever
// - modes 3,6 hold last stage frequency after cycle
// - modes 1-3 resume at the unfinished step
// - modes 4-6 restart from first step
// - stage frequency (stages 1-15), time, direction from settings
// - wobble or pid enabled inhibits sequencer
// - all sixteen stage times zero inhibits sequencer
// - multi-step speed inputs ignored while enabled
// - stage 0 frequency from multi-step speed 0
// - ramps use primary accel/decel times
// - stage frequency 0-400 Hz, 0.1 Hz above 300
// - stage times 0.0 to 6000.0 seconds
// - direction codes: 0 stop, 1 fwd, 2 rev
// - sixteen stages, each with own direction
// - single cycle stops output after last stage
`timescale 1ns/10ps
`default_nettype none
module aps_sequencer #(
  parameter int unsigned TICK_CYCLES = aps_pkg::TICK_CYCLES
)(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // drive context
  input wire logic run_fwd_i,
  input wire logic run_rev_i,
  input wire logic [15:0] normal_freq_i,
  input wire logic [15:0] speed0_freq_i,
  input wire logic wobble_en_i,
  input wire logic pid_en_i,
  input wire logic [3:0] step_sel_i,
  // drive commands
  output logic [15:0] freq_ref_o,
  output logic fwd_o,
  output logic rev_o,
  output logic [3:0] step_sel_o,
  output logic primary_ramp_o,
  output logic auto_active_o
);

  function automatic aps_pkg::aps_kind_t mode_kind(input logic [15:0] m);
    aps_pkg::aps_kind_t k;
    k = aps_pkg::KIND_OFF;
    if (m == aps_pkg::MODE_OFF_VAL || m > aps_pkg::MODE_MAX)
      k = aps_pkg::KIND_OFF;
    else if (m == 16'h0001 || m == 16'h0004)
      k = aps_pkg::KIND_SINGLE;
    else if (m == 16'h0002 || m == 16'h0005)
      k = aps_pkg::KIND_CONT;
    else
      k = aps_pkg::KIND_HOLD;
    return k;
  endfunction

  // above the fine band only 0.1 Hz steps are kept
  function automatic logic [15:0] fit_freq(input logic [15:0] f);
    logic [15:0] c;
    c = (f > aps_pkg::FREQ_MAX) ? aps_pkg::FREQ_MAX : f;
    if (c > aps_pkg::FREQ_FINE_MAX)
      c = c - (c % aps_pkg::FREQ_COARSE_STEP);
    return c;
  endfunction

  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  logic [15:0] mode;
  logic [15:0] stage_freq [aps_pkg::NUM_STAGES];
  logic [15:0] stage_time [aps_pkg::NUM_STAGES];
  logic [15:0] stage_dir [aps_pkg::NUM_STAGES];
  aps_pkg::aps_state_t state;
  logic [3:0] stage;
  logic [15:0] elapsed;
  logic [31:0] prescale;
  logic at_last;
  localparam logic [3:0] FIRST_IDX = 4'h0;
  localparam logic [3:0] STATUS_IDX = 4'h1;

  logic wr_en;
  logic [1:0] grp;
  logic [3:0] idx;
  logic mapped;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign grp = paddr_i[7:6];
  assign idx = paddr_i[5:2];
  assign mapped = (paddr_i[1:0] == 2'b00) &&
    ((grp != aps_pkg::REG_GROUP_STAT) || (idx == FIRST_IDX) || (idx == STATUS_IDX));

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // settings; out-of-range frequency and time writes are clamped, out-of-range mode and direction writes load zero
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= aps_pkg::MODE_OFF_VAL;
      for (int i = 0; i < aps_pkg::NUM_STAGES; i++)
      begin
        stage_freq[i] <= 16'h0000;
        stage_time[i] <= 16'h0000;
        stage_dir[i] <= aps_pkg::DIR_STOP;
      end
    end
    else if (wr_en && mapped)
    begin
      unique case (grp)
        aps_pkg::REG_GROUP_FREQ:
        begin
          if (idx == FIRST_IDX)
            mode <= (pwdata_i[15:0] > aps_pkg::MODE_MAX) ? aps_pkg::MODE_OFF_VAL : pwdata_i[15:0];
          else
            stage_freq[idx] <= fit_freq(pwdata_i[15:0]);
        end
        aps_pkg::REG_GROUP_TIME:
          stage_time[idx] <= (pwdata_i[15:0] > aps_pkg::TIME_MAX) ? aps_pkg::TIME_MAX : pwdata_i[15:0];
        aps_pkg::REG_GROUP_DIR:
          stage_dir[idx] <= (pwdata_i[15:0] > aps_pkg::DIR_REV) ? aps_pkg::DIR_STOP : pwdata_i[15:0];
        aps_pkg::REG_GROUP_STAT:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      prdata_o <= 32'h0000_0000;
      unique case (grp)
        aps_pkg::REG_GROUP_FREQ:
          prdata_o[15:0] <= (idx == FIRST_IDX) ? mode : stage_freq[idx];
        aps_pkg::REG_GROUP_TIME:
          prdata_o[15:0] <= stage_time[idx];
        aps_pkg::REG_GROUP_DIR:
          prdata_o[15:0] <= stage_dir[idx];
        aps_pkg::REG_GROUP_STAT:
          if (idx == STATUS_IDX)
            prdata_o <= {8'h00, elapsed, 1'b0, at_last, state, stage};
      endcase
    end
  end

  aps_pkg::aps_kind_t kind;
  logic any_time;
  logic enabled;
  logic run_cmd;
  logic resume_mode;
  logic tick;
  logic stage_over;
  assign kind = mode_kind(mode);
  always_comb
  begin
    any_time = 1'b0;
    for (int i = 0; i < aps_pkg::NUM_STAGES; i++)
      any_time = any_time | (stage_time[i] != 16'h0000);
  end
  assign enabled = (kind != aps_pkg::KIND_OFF)
    && !wobble_en_i && !pid_en_i
    && any_time;
  assign run_cmd = run_fwd_i || run_rev_i;
  assign resume_mode = mode <= aps_pkg::MODE_RESUME_MAX;
  assign tick = prescale == (TICK_CYCLES - 1);
  // a zero-time stage is passed straight through
  assign stage_over = elapsed >= stage_time[stage];

  // tenths-of-a-second base; only runs while a stage is timing
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= 32'h0000_0000;
    else if (state != aps_pkg::ST_RUN || stage_over || tick)
      prescale <= 32'h0000_0000;
    else
      prescale <= prescale + 32'h0000_0001;
  end

  aps_pkg::aps_state_t next_state;
  logic [3:0] next_stage;
  logic [15:0] next_elapsed;
  logic next_at_last;
  always_comb
  begin
    next_state = state;
    next_stage = stage;
    next_elapsed = elapsed;
    next_at_last = at_last;
    if (!enabled)
    begin
      next_state = aps_pkg::ST_IDLE;
      next_stage = FIRST_IDX;
      next_elapsed = 16'h0000;
      next_at_last = 1'b0;
    end
    else
    begin
      unique case (state)
        aps_pkg::ST_IDLE:
          if (run_cmd)
          begin
            if (!resume_mode)
            begin
              next_stage = aps_pkg::FIRST_STAGE;
              next_elapsed = 16'h0000;
              next_at_last = 1'b0;
              next_state = aps_pkg::ST_RUN;
            end
            else
              next_state = at_last ? aps_pkg::ST_HOLD : aps_pkg::ST_RUN;
          end
        aps_pkg::ST_RUN:
          if (!run_cmd)
            next_state = aps_pkg::ST_IDLE;
          else if (stage_over)
          begin
            next_elapsed = 16'h0000;
            if (stage != aps_pkg::LAST_STAGE)
              next_stage = stage + 4'h1;
            else
            begin
              unique case (kind)
                aps_pkg::KIND_CONT:
                  next_stage = aps_pkg::FIRST_STAGE;
                aps_pkg::KIND_HOLD:
                begin
                  next_state = aps_pkg::ST_HOLD;
                  next_at_last = 1'b1;
                end
                default:
                  next_state = aps_pkg::ST_DONE;
              endcase
            end
          end
          else if (tick)
            next_elapsed = elapsed + 16'h0001;
        aps_pkg::ST_HOLD:
          if (!run_cmd)
            next_state = aps_pkg::ST_IDLE;
        aps_pkg::ST_DONE:
          // a finished cycle starts over on the next run
          if (!run_cmd)
          begin
            next_state = aps_pkg::ST_IDLE;
            next_stage = aps_pkg::FIRST_STAGE;
            next_at_last = 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= aps_pkg::ST_IDLE;
      stage <= aps_pkg::FIRST_STAGE;
      elapsed <= 16'h0000;
      at_last <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stage <= next_stage;
      elapsed <= next_elapsed;
      at_last <= next_at_last;
    end
  end

  logic [15:0] cur_freq;
  logic [15:0] cur_dir;
  logic driving;
  assign cur_freq = (stage == aps_pkg::FIRST_STAGE) ? speed0_freq_i : stage_freq[stage];
  assign cur_dir = stage_dir[stage];
  assign driving = state == aps_pkg::ST_RUN || state == aps_pkg::ST_HOLD;

  // commands are registered; idle/done in auto mode means output stopped
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_ref_o <= 16'h0000;
      fwd_o <= 1'b0;
      rev_o <= 1'b0;
      auto_active_o <= 1'b0;
    end
    else if (!enabled)
    begin
      freq_ref_o <= normal_freq_i;
      fwd_o <= run_fwd_i;
      rev_o <= run_rev_i && !run_fwd_i;
      auto_active_o <= 1'b0;
    end
    else if (driving && cur_dir != aps_pkg::DIR_STOP)
    begin
      freq_ref_o <= cur_freq;
      fwd_o <= cur_dir == aps_pkg::DIR_FWD;
      rev_o <= cur_dir == aps_pkg::DIR_REV;
      auto_active_o <= 1'b1;
    end
    else
    begin
      freq_ref_o <= 16'h0000;
      fwd_o <= 1'b0;
      rev_o <= 1'b0;
      auto_active_o <= driving;
    end
  end

  assign step_sel_o = enabled ? 4'h0 : step_sel_i;
  assign primary_ramp_o = enabled;

endmodule
`default_nettype wire

/* include/aps_pkg.sv */
// constants for the automatic stage sequencer
package aps_pkg;
  localparam int unsigned NUM_STAGES = 16;
  localparam logic [3:0] LAST_STAGE = 4'hf;
  localparam logic [3:0] FIRST_STAGE = 4'h0;
  // byte offsets of the register map
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] FREQ_BASE = 8'h00;
  localparam logic [7:0] TIME_BASE = 8'h40;
  localparam logic [7:0] DIR_BASE = 8'h80;
  localparam logic [7:0] STATUS_OFF = 8'hc0;
  localparam logic [1:0] REG_GROUP_FREQ = 2'h0;
  localparam logic [1:0] REG_GROUP_TIME = 2'h1;
  localparam logic [1:0] REG_GROUP_DIR = 2'h2;
  localparam logic [1:0] REG_GROUP_STAT = 2'h3;
  // mode selector values
  localparam logic [15:0] MODE_OFF_VAL = 16'h0000;
  localparam logic [15:0] MODE_RESUME_MAX = 16'h0003;
  localparam logic [15:0] MODE_MAX = 16'h0006;
  // frequency in 0.01 Hz units
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  localparam logic [15:0] FREQ_FINE_MAX = 16'h7530;
  localparam logic [15:0] FREQ_COARSE_STEP = 16'h000a;
  // stage time in 0.1 s units
  localparam logic [15:0] TIME_MAX = 16'hea60;
  // stage direction codes
  localparam logic [15:0] DIR_STOP = 16'h0000;
  localparam logic [15:0] DIR_FWD = 16'h0001;
  localparam logic [15:0] DIR_REV = 16'h0002;
  // timer base
  localparam int unsigned TIME_UNIT_NS = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {KIND_OFF, KIND_SINGLE, KIND_CONT, KIND_HOLD} aps_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_DONE} aps_state_t;
endpackage

/* verif/aps_sequencer_chk.sv */
// port-level assertions for the stage sequencer
`timescale 1ns/10ps
`default_nettype none
module aps_sequencer_chk #(
  parameter int unsigned TICK_CYCLES = 2
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_fwd_i,
  input wire logic run_rev_i,
  input wire logic [15:0] normal_freq_i,
  input wire logic wobble_en_i,
  input wire logic pid_en_i,
  input wire logic [3:0] step_sel_i,
  input wire logic [15:0] freq_ref_o,
  input wire logic fwd_o,
  input wire logic rev_o,
  input wire logic [3:0] step_sel_o,
  input wire logic primary_ramp_o,
  input wire logic auto_active_o
);
  // the design leaves reset two edges after the pin, so wait that out
  logic [1:0] settle;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      settle <= 2'h0;
    else if (settle != 2'h3)
      settle <= settle + 2'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || settle != 2'h3);
  a_off_freq: assert property (!primary_ramp_o |=> freq_ref_o == $past(normal_freq_i))
    else $error("bypass frequency wrong");
  a_off_dir: assert property (!primary_ramp_o |=> fwd_o == $past(run_fwd_i) && rev_o == $past(run_rev_i && !run_fwd_i))
    else $error("bypass direction wrong");
  a_step_mask: assert property (primary_ramp_o |-> step_sel_o == 4'h0)
    else $error("step inputs not masked");
  a_step_pass: assert property (!primary_ramp_o |-> step_sel_o == step_sel_i)
    else $error("step inputs not passed");
  a_dir_excl: assert property (!(fwd_o && rev_o))
    else $error("both directions commanded");
  a_stop_zero: assert property (auto_active_o && !fwd_o && !rev_o |-> freq_ref_o == 16'h0)
    else $error("stop stage with nonzero frequency");
  a_inhibit_fn: assert property ((wobble_en_i || pid_en_i) |-> !primary_ramp_o ##1 !auto_active_o)
    else $error("sequencer active while inhibited");
  a_ramp_primary: assert property ($rose(auto_active_o) |-> $past(primary_ramp_o) && primary_ramp_o)
    else $error("primary ramp not selected");
  a_run_stop: assert property (primary_ramp_o && !run_fwd_i && !run_rev_i |-> ##2 !auto_active_o)
    else $error("sequencer runs without run command");
  c_start: cover property ($rose(auto_active_o));
  c_stop_stage: cover property (auto_active_o && !fwd_o && !rev_o);
  c_rev_stage: cover property (auto_active_o && rev_o);
  c_inhibit: cover property (wobble_en_i && !primary_ramp_o);
endmodule
bind aps_sequencer aps_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .run_fwd_i(run_fwd_i), .run_rev_i(run_rev_i),
  .normal_freq_i(normal_freq_i), .wobble_en_i(wobble_en_i), .pid_en_i(pid_en_i), .step_sel_i(step_sel_i),
  .freq_ref_o(freq_ref_o), .fwd_o(fwd_o), .rev_o(rev_o), .step_sel_o(step_sel_o),
  .primary_ramp_o(primary_ramp_o), .auto_active_o(auto_active_o)
);
`default_nettype wire

/* verif/aps_sequencer_bench.sv */
// self-checking bench for the stage sequencer
`timescale 1ns/10ps
`default_nettype none
module aps_sequencer_bench;
  typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] x;} aps_row_t;
  logic clk, rst_n, psel, pen, pwr, run_f, run_r, wob, pid, pready, perr, fwd, rev, ramp, act, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] nfreq, s0f, freq;
  logic [3:0] ssel, ssel_o;
  int err_total, checks_done;
  // clamping rows: out-of-range settings read back clamped, or zero for mode and direction
  aps_row_t rows [9] = '{'{8'h04, 16'h9c41, 16'h9c40}, '{8'h08, 16'h7535, 16'h7530}, '{8'h3c, 16'h1234, 16'h1234},
    '{8'h40, 16'hea61, 16'hea60}, '{8'h7c, 16'h0064, 16'h0064}, '{8'h80, 16'h0003, 16'h0000},
    '{8'hbc, 16'h0002, 16'h0002}, '{8'h84, 16'h0001, 16'h0001}, '{8'h00, 16'h0007, 16'h0000}};
  logic [7:0] ca [10] = '{8'h40, 8'h44, 8'h4c, 8'h7c, 8'h80, 8'h84, 8'hbc, 8'h04, 8'h0c, 8'h3c};
  logic [15:0] cd [10] = '{16'h3, 16'h5, 16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h0bb8, 16'h0100, 16'h07d0};

  aps_sequencer #(.TICK_CYCLES(2)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .run_fwd_i(run_f),
    .run_rev_i(run_r), .normal_freq_i(nfreq), .speed0_freq_i(s0f), .wobble_en_i(wob), .pid_en_i(pid),
    .step_sel_i(ssel), .freq_ref_o(freq), .fwd_o(fwd), .rev_o(rev), .step_sel_o(ssel_o),
    .primary_ramp_o(ramp), .auto_active_o(act)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // bounded wait for a frequency command, then compare it
  task automatic wait_f(input logic [15:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (freq !== v && n < 200);
    chk(32'(freq), 32'(v));
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic set_mode(input int m);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'(m));
    run_f <= 1'b1;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    err_total = 0;
    checks_done = 0;
    {rst_n, psel, pen, pwr, run_f, run_r, wob, pid} = '0;
    paddr = '0;
    pwdata = '0;
    nfreq = '0;
    s0f = '0;
    ssel = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk(32'(freq), 32'h0);
    @(posedge clk);
    nfreq <= 16'h1234;
    s0f <= 16'h05dc;
    run_f <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, 32'(rows[i].w));
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, 32'(rows[i].x));
    end
    @(negedge clk);
    chk(32'({fwd, freq}), 32'h0001_1234);
    apb(1'b0, 8'hd0, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, 8'(8'h40 + 4 * i), 32'h0);
      apb(1'b1, 8'(8'h80 + 4 * i), 32'h0);
    end
    apb(1'b1, 8'h00, 32'h4);
    @(negedge clk);
    chk(32'({ramp, freq}), 32'h0000_1234);
    @(posedge clk);
    run_f <= 1'b0;
    foreach (ca[i])
      apb(1'b1, ca[i], 32'(cd[i]));
    // modes 1-6: walk the stages, then look past the last one
    for (int m = 1; m <= 6; m++)
    begin
      set_mode(m);
      wait_f(16'h05dc);
      chk(32'(fwd), 32'h1);
      wait_f(16'h0bb8);
      wait_f(16'h07d0);
      chk(32'(rev), 32'h1);
      repeat (6) @(negedge clk);
      chk(32'(freq), m % 3 == 1 ? 32'h0 : m % 3 == 2 ? 32'h05dc : 32'h07d0);
      chk(32'(act), m % 3 == 1 ? 32'h0 : 32'h1);
      @(posedge clk);
      run_f <= 1'b0;
    end
    // stop inside stage 1, then run again
    for (int m = 1; m <= 4; m += 3)
    begin
      set_mode(m);
      wait_f(16'h0bb8);
      @(posedge clk);
      run_f <= 1'b0;
      repeat (3) @(posedge clk);
      run_f <= 1'b1;
      repeat (4) @(negedge clk);
      chk(32'(freq), m == 1 ? 32'h0bb8 : 32'h05dc);
    end
    @(posedge clk);
    ssel <= 4'h5;
    repeat (2) @(negedge clk);
    chk(32'(ssel_o), 32'h0);
    @(posedge clk);
    wob <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({ramp, ssel_o, freq}), 32'h0005_1234);
    @(posedge clk);
    wob <= 1'b0;
    pid <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({ramp, freq}), 32'h0000_1234);
    @(posedge clk);
    pid <= 1'b0;
    run_f <= 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire
